/* rtl/rat_pkg.sv */
// package: register map, field layout, reset values and timing for alarm and trim block
package rat_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h07;
    localparam logic [7:0] ADDR_EVENT_CTRL = 8'h08;
    localparam logic [7:0] ADDR_ANALOG_TRIM = 8'h0a;
    localparam logic [7:0] ADDR_DIGITAL_TRIM = 8'h0b;
    localparam logic [7:0] ADDR_ALARM_FIRST = 8'h0c;
    localparam logic [7:0] ADDR_ALARM_LAST = 8'h11;
    localparam int ALARM_BYTES = 6;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ST_AUTO_CLEAR_BIT = 7;
    localparam int ST_ALARM_FLAG_BIT = 2;
    localparam int CTL_PERIODIC_BIT = 7;
    localparam int CTL_ALARM_EN_BIT = 6;
    localparam int CTL_FREQ_SEL_MSB = 3;
    localparam int ALT_TOP_BIT = 5;
    localparam int ALT_OFFSET_MSB = 7;
    localparam int ALT_OFFSET_LSB = 6;
    localparam int RT_SIGN_BIT = 2;
    localparam int RT_BIG_BIT = 1;
    localparam int RT_SMALL_BIT = 0;
    localparam int ALARM_CMP_EN_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] RST_EVENT_CTRL = 8'h00;
    localparam logic [7:0] RST_ANALOG_TRIM = 8'h00;
    localparam logic [7:0] RST_DIGITAL_TRIM = 8'h00;
    localparam logic [7:0] RST_ALARM = 8'h00;
    localparam logic RST_AUTO_CLEAR = 1'b0;
    localparam logic RST_ALARM_FLAG = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // capacitance in half-pF steps per pin, quarter-pF steps for series load
    localparam logic [6:0] CAP_BASE_HALF_PF = 7'h12;
    localparam logic [6:0] CAP_TOP_WEIGHT_HALF_PF = 7'h20;
    localparam logic signed [7:0] BAT_OFS_NONE_QPF = 8'sh00;
    localparam logic signed [7:0] BAT_OFS_MINUS_HALF_QPF = -8'sh02;
    localparam logic signed [7:0] BAT_OFS_PLUS_HALF_QPF = 8'sh02;
    localparam logic signed [7:0] BAT_OFS_PLUS_ONE_QPF = 8'sh04;

    // rate trim magnitudes in ppm
    localparam logic [7:0] RATE_BIG_PPM = 8'h28;
    localparam logic [7:0] RATE_SMALL_PPM = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int PULSE_TIME_MS = 250;
    localparam int PULSE_CYCLES = PULSE_TIME_MS * (CLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0] weekday;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } rat_time_t;

    typedef struct packed {
        logic wr;
        logic rd_done;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rat_regreq_t;

    typedef struct packed {
        logic [6:0] cx_half_pf;
        logic [6:0] load_qpf;
        logic signed [7:0] rate_ppm;
    } rat_trim_t;

endpackage

/* rtl/rat_alarm_trim.sv */
// alarm match, event pin control and oscillator trim decode
//
// Function
// - pin capacitor from analog trim weights plus 9pF
// - series load 4.5 to 20.25pF, quarter steps
// - battery offset adjusts load while on battery
// - rate trim sets average counts per second
// - rate trim top bit is correction sign
// - lower bits weigh 40 and 20 ppm
// - six alarm bytes, bit 7 enables compare
// - no year alarm byte, six fields only
// - trigger when all enabled bytes match and at least one byte is enabled
// - single mode: flag set, pin held low
// - periodic mode: pulse pin on each match
// - write zero or auto-clear read clears flag
// - trigger at the update reaching match
// - periodic pulses continue regardless of flag
// - periodic pulse active low, 250 ms
// - nonzero frequency code overrides alarm on pin
// - writing one never sets the flag
module rat_alarm_trim #(
    parameter int PULSE_CYCLES = rat_pkg::PULSE_CYCLES
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // register access from serial interface
    input wire rat_pkg::rat_regreq_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    // calendar
    input wire logic sec_tick_in,
    input wire rat_pkg::rat_time_t time_in,
    // pins and supply state
    input wire logic on_battery_in,
    input wire logic fout_wave_in,
    output logic event_b_out,
    // oscillator and timebase controls
    output logic [3:0] frequency_out_select_out,
    output rat_pkg::rat_trim_t trim_out
);

    localparam int PW = $clog2(PULSE_CYCLES + 1);
    localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic is_alarm_addr(input logic [7:0] a);
        is_alarm_addr = (a >= rat_pkg::ADDR_ALARM_FIRST) && (a <= rat_pkg::ADDR_ALARM_LAST);
    endfunction

    function automatic logic [2:0] alarm_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - rat_pkg::ADDR_ALARM_FIRST;
        alarm_index = d[2:0];
    endfunction

    function automatic logic is_status(input logic [7:0] a);
        is_status = a == rat_pkg::ADDR_STATUS;
    endfunction

    function automatic logic signed [7:0] battery_offset(input logic [1:0] code);
        case (code)
            2'h1: battery_offset = rat_pkg::BAT_OFS_MINUS_HALF_QPF;
            2'h2: battery_offset = rat_pkg::BAT_OFS_PLUS_HALF_QPF;
            2'h3: battery_offset = rat_pkg::BAT_OFS_PLUS_ONE_QPF;
            default: battery_offset = rat_pkg::BAT_OFS_NONE_QPF;
        endcase
    endfunction

    function automatic logic [7:0] rate_magnitude(input logic [1:0] code);
        rate_magnitude = 8'h00;
        if (code[1]) begin
            rate_magnitude = rate_magnitude + rat_pkg::RATE_BIG_PPM;
        end
        if (code[0]) begin
            rate_magnitude = rate_magnitude + rat_pkg::RATE_SMALL_PPM;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] event_ctrl, next_event_ctrl;
    logic [7:0] analog_load_trim_reg, next_analog_load_trim_reg;
    logic [7:0] digital_rate_trim_reg, next_digital_rate_trim_reg;
    logic [7:0] alarm_match [rat_pkg::ALARM_BYTES];
    logic [7:0] next_alarm_match [rat_pkg::ALARM_BYTES];
    logic auto_clear_on_read, next_auto_clear_on_read;
    logic alarm_flag, next_alarm_flag;
    logic [7:0] next_reg_rdata;
    logic tick_q, next_tick_q;
    logic alarm_hit;

    logic wr_status;
    logic rd_status;
    assign wr_status = reg_req_in.wr && is_status(reg_req_in.addr);
    assign rd_status = reg_req_in.rd_done && is_status(reg_req_in.addr);

    // configuration registers and alarm bytes
    always_comb begin
        next_event_ctrl = event_ctrl;
        next_analog_load_trim_reg = analog_load_trim_reg;
        next_digital_rate_trim_reg = digital_rate_trim_reg;
        next_alarm_match = alarm_match;
        next_auto_clear_on_read = auto_clear_on_read;
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                rat_pkg::ADDR_STATUS: begin
                    next_auto_clear_on_read = reg_req_in.wdata[rat_pkg::ST_AUTO_CLEAR_BIT];
                end
                rat_pkg::ADDR_EVENT_CTRL: begin
                    next_event_ctrl = reg_req_in.wdata;
                end
                rat_pkg::ADDR_ANALOG_TRIM: begin
                    next_analog_load_trim_reg = reg_req_in.wdata;
                end
                rat_pkg::ADDR_DIGITAL_TRIM: begin
                    next_digital_rate_trim_reg = reg_req_in.wdata;
                end
                default: begin
                    if (is_alarm_addr(reg_req_in.addr)) begin
                        next_alarm_match[alarm_index(reg_req_in.addr)] = reg_req_in.wdata;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            event_ctrl <= rat_pkg::RST_EVENT_CTRL;
            analog_load_trim_reg <= rat_pkg::RST_ANALOG_TRIM;
            digital_rate_trim_reg <= rat_pkg::RST_DIGITAL_TRIM;
            for (int i = 0; i < rat_pkg::ALARM_BYTES; i++) begin
                alarm_match[i] <= rat_pkg::RST_ALARM;
            end
            auto_clear_on_read <= rat_pkg::RST_AUTO_CLEAR;
        end else if (ce_in) begin
            event_ctrl <= next_event_ctrl;
            analog_load_trim_reg <= next_analog_load_trim_reg;
            digital_rate_trim_reg <= next_digital_rate_trim_reg;
            alarm_match <= next_alarm_match;
            auto_clear_on_read <= next_auto_clear_on_read;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm flag and second update
    always_comb begin
        next_alarm_flag = alarm_flag;
        next_tick_q = sec_tick_in;
        // a write can only clear the flag
        if (wr_status && !reg_req_in.wdata[rat_pkg::ST_ALARM_FLAG_BIT]) begin
            next_alarm_flag = 1'b0;
        end
        if (rd_status && auto_clear_on_read) begin
            next_alarm_flag = 1'b0;
        end
        // a new match wins over any clear
        if (alarm_hit) begin
            next_alarm_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            alarm_flag <= rat_pkg::RST_ALARM_FLAG;
            tick_q <= 1'b0;
        end else if (ce_in) begin
            alarm_flag <= next_alarm_flag;
            tick_q <= next_tick_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle behind the address
    always_comb begin
        next_reg_rdata = 8'h00;
        case (reg_req_in.addr)
            rat_pkg::ADDR_STATUS: begin
                next_reg_rdata[rat_pkg::ST_AUTO_CLEAR_BIT] = auto_clear_on_read;
                next_reg_rdata[rat_pkg::ST_ALARM_FLAG_BIT] = alarm_flag;
            end
            rat_pkg::ADDR_EVENT_CTRL: begin
                next_reg_rdata = event_ctrl;
            end
            rat_pkg::ADDR_ANALOG_TRIM: begin
                next_reg_rdata = analog_load_trim_reg;
            end
            rat_pkg::ADDR_DIGITAL_TRIM: begin
                next_reg_rdata = digital_rate_trim_reg;
            end
            default: begin
                if (is_alarm_addr(reg_req_in.addr)) begin
                    next_reg_rdata = alarm_match[alarm_index(reg_req_in.addr)];
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= 8'h00;
        end else if (ce_in) begin
            reg_rdata_out <= next_reg_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm comparison
    logic [rat_pkg::ALARM_BYTES-1:0][7:0] time_bytes;
    logic [rat_pkg::ALARM_BYTES-1:0] byte_ok;
    logic [rat_pkg::ALARM_BYTES-1:0] byte_en;
    logic freq_active;
    logic alarm_active;

    assign time_bytes = time_in;

    genvar g;
    generate
        for (g = 0; g < rat_pkg::ALARM_BYTES; g++) begin : g_cmp
            assign byte_en[g] = alarm_match[g][rat_pkg::ALARM_CMP_EN_BIT];
            assign byte_ok[g] = !byte_en[g] || (alarm_match[g][6:0] == time_bytes[g][6:0]);
        end
    endgenerate

    assign freq_active = |event_ctrl[rat_pkg::CTL_FREQ_SEL_MSB:0];
    assign alarm_active = event_ctrl[rat_pkg::CTL_ALARM_EN_BIT] && !freq_active;
    // evaluated once, the cycle after each second update
    assign alarm_hit = tick_q && alarm_active && (|byte_en) && (&byte_ok);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] bat_sync, next_bat_sync;
    logic [2:0] wave_sync, next_wave_sync;
    logic bat_level, next_bat_level;
    logic wave_level, next_wave_level;

    always_comb begin
        next_bat_sync = {bat_sync[1:0], on_battery_in};
        next_wave_sync = {wave_sync[1:0], fout_wave_in};
        next_bat_level = bat_level;
        next_wave_level = wave_level;
        if (bat_sync[1] == bat_sync[2]) begin
            next_bat_level = bat_sync[2];
        end
        if (wave_sync[1] == wave_sync[2]) begin
            next_wave_level = wave_sync[2];
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            bat_sync <= 3'h0;
            wave_sync <= 3'h0;
            bat_level <= 1'b0;
            wave_level <= 1'b0;
        end else if (ce_in) begin
            bat_sync <= next_bat_sync;
            wave_sync <= next_wave_sync;
            bat_level <= next_bat_level;
            wave_level <= next_wave_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event pin and trim outputs
    logic [PW-1:0] pulse_cnt, next_pulse_cnt;
    logic next_event_b;
    logic [6:0] cx_half;
    logic signed [7:0] bat_ofs;
    logic signed [7:0] load_sum;
    logic [7:0] rate_mag;
    rat_pkg::rat_trim_t next_trim;

    always_comb begin
        next_pulse_cnt = pulse_cnt;
        if (pulse_cnt != '0) begin
            next_pulse_cnt = pulse_cnt - PW'(1);
        end
        if (alarm_hit && event_ctrl[rat_pkg::CTL_PERIODIC_BIT]) begin
            next_pulse_cnt = PULSE_LOAD;
        end
        // pin drive priority
        if (freq_active) begin
            next_event_b = wave_level;
        end else if (!alarm_active) begin
            next_event_b = 1'b1;
        end else if (event_ctrl[rat_pkg::CTL_PERIODIC_BIT]) begin
            next_event_b = !((pulse_cnt != '0) || alarm_hit);
        end else begin
            next_event_b = !next_alarm_flag;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pulse_cnt <= '0;
            event_b_out <= 1'b1;
            frequency_out_select_out <= 4'h0;
        end else if (ce_in) begin
            pulse_cnt <= next_pulse_cnt;
            event_b_out <= next_event_b;
            frequency_out_select_out <= next_event_ctrl[rat_pkg::CTL_FREQ_SEL_MSB:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator trim decode
    always_comb begin
        // analog load trim
        cx_half = rat_pkg::CAP_BASE_HALF_PF + {2'b00, analog_load_trim_reg[4:0]};
        if (!analog_load_trim_reg[rat_pkg::ALT_TOP_BIT]) begin
            cx_half = cx_half + rat_pkg::CAP_TOP_WEIGHT_HALF_PF;
        end
        bat_ofs = battery_offset(analog_load_trim_reg[rat_pkg::ALT_OFFSET_MSB:rat_pkg::ALT_OFFSET_LSB]);
        if (!bat_level) begin
            bat_ofs = rat_pkg::BAT_OFS_NONE_QPF;
        end
        // series load of two equal pins: half-pF per pin equals quarter-pF load
        load_sum = $signed({1'b0, cx_half}) + bat_ofs;
        // digital rate trim
        rate_mag = rate_magnitude(digital_rate_trim_reg[rat_pkg::RT_BIG_BIT:rat_pkg::RT_SMALL_BIT]);
        next_trim.cx_half_pf = cx_half;
        next_trim.load_qpf = load_sum[6:0];
        if (digital_rate_trim_reg[rat_pkg::RT_SIGN_BIT]) begin
            next_trim.rate_ppm = -$signed(rate_mag);
        end else begin
            next_trim.rate_ppm = $signed(rate_mag);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            trim_out <= '0;
        end else if (ce_in) begin
            trim_out <= next_trim;
        end
    end

endmodule

/* verif/rat_alarm_trim_properties.sv */
// checker: port-level properties of the alarm and trim block
module rat_alarm_trim_checker #(
    parameter int PULSE_CYCLES = 20
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // register access
    input wire rat_pkg::rat_regreq_t reg_req_in,
    input wire logic [7:0] reg_rdata_out,
    // calendar
    input wire logic sec_tick_in,
    input wire rat_pkg::rat_time_t time_in,
    // pins and controls
    input wire logic on_battery_in,
    input wire logic fout_wave_in,
    input wire logic event_b_out,
    input wire logic [3:0] frequency_out_select_out,
    input wire rat_pkg::rat_trim_t trim_out
);
    logic [1:0] up_cnt;
    logic [1:0] next_up_cnt;
    int load_delta;
    always_comb begin
        next_up_cnt = (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            up_cnt <= 2'h0;
        end else begin
            up_cnt <= next_up_cnt;
        end
    end
    assign load_delta = int'(trim_out.load_qpf) - int'(trim_out.cx_half_pf);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////////////////////////////////////////
    load_tracks_a: assert property (
        (up_cnt == 2'h3 && !on_battery_in && ce_in)[*6] |-> load_delta == 0)
        else $error("series load differs from pin value on mains");
    cx_range_a: assert property (
        up_cnt == 2'h3 |-> trim_out.cx_half_pf inside {[7'h12:7'h51]})
        else $error("pin capacitance out of range");
    battery_offset_a: assert property (
        (up_cnt == 2'h3 && on_battery_in && ce_in)[*6] |-> load_delta inside {-2, 0, 2, 4})
        else $error("battery load offset not a legal step");
    rate_values_a: assert property (
        up_cnt == 2'h3 |-> trim_out.rate_ppm inside {8'sh00, 8'sh14, 8'sh28, 8'sh3c, -8'sh14, -8'sh28, -8'sh3c})
        else $error("rate correction not a legal value");
    alarm_after_tick_a: assert property (
        (frequency_out_select_out == 4'h0)[*3] ##0 $fell(event_b_out) |-> $past(sec_tick_in, 2))
        else $error("event pin fell without a second update");
    wave_high_a: assert property (
        (frequency_out_select_out != 4'h0 && fout_wave_in && ce_in)[*6] |-> event_b_out)
        else $error("event pin not following high wave");
    wave_low_a: assert property (
        (frequency_out_select_out != 4'h0 && !fout_wave_in && ce_in)[*6] |-> !event_b_out)
        else $error("event pin not following low wave");
    state_freeze_a: assert property (
        !ce_in |=> $stable(trim_out) && $stable(event_b_out) && $stable(reg_rdata_out))
        else $error("state moved while clock enable low");
endmodule

bind rat_alarm_trim rat_alarm_trim_checker #(.PULSE_CYCLES(PULSE_CYCLES)) rat_alarm_trim_checker_inst (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .reg_req_in(reg_req_in),
    .reg_rdata_out(reg_rdata_out), .sec_tick_in(sec_tick_in), .time_in(time_in),
    .on_battery_in(on_battery_in), .fout_wave_in(fout_wave_in), .event_b_out(event_b_out),
    .frequency_out_select_out(frequency_out_select_out), .trim_out(trim_out)
);

/* verif/rat_host_model.sv */
// host model: register writes and reads over the block's request port
module rat_host_model (
    // clock
    input wire logic clk_in,
    // register port toward the block
    input wire logic [7:0] reg_rdata_in,
    output rat_pkg::rat_regreq_t reg_req_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial reg_req_out = '0;
    // one-cycle write strobe, then one idle cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_req_out.addr = a;
        reg_req_out.wdata = d;
        reg_req_out.wr = 1'b1;
        @(negedge clk_in);
        reg_req_out.wr = 1'b0;
        @(negedge clk_in);
    endtask
    // read, optionally closed with the end-of-read strobe
    task automatic rd(input logic [7:0] a, input logic clr, output logic [7:0] d);
        reg_req_out.addr = a;
        repeat (2) @(negedge clk_in);
        d = reg_rdata_in;
        reg_req_out.rd_done = clr;
        @(negedge clk_in);
        reg_req_out.rd_done = 1'b0;
        @(negedge clk_in);
    endtask
endmodule

/* verif/rat_alarm_trim_tb.sv */
// testbench: register, trim, alarm and event pin checks
module rat_alarm_trim_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PC = 20;
    localparam logic [47:0] T_MATCH = 48'h03_01_01_11_30_00;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic ce_in = 1'b1;
    logic sec_tick_in = 1'b0;
    logic on_battery_in = 1'b0;
    logic fout_wave_in = 1'b0;
    rat_pkg::rat_time_t time_in = '0;
    rat_pkg::rat_regreq_t reg_req;
    logic [7:0] reg_rdata_out;
    logic event_b_out;
    logic [3:0] frequency_out_select_out;
    rat_pkg::rat_trim_t trim_out;
    logic [7:0] rv;
    logic [47:0] t;
    logic [7:0] regs [11] = '{8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h14};
    logic [7:0] ana [4] = '{8'h00, 8'h60, 8'h9f, 8'hd5};
    logic [7:0] al1 [6] = '{8'h00, 8'hb0, 8'h91, 8'h81, 8'h81, 8'h00};
    int bo [4] = '{0, -2, 2, 4};
    int rt [8] = '{0, 20, 40, 60, 0, -20, -40, -60};
    int n_fail = 0;
    int total_checks = 0;
    int lo;
    int e;
    always #25 clk_in = ~clk_in;
    rat_alarm_trim #(.PULSE_CYCLES(PC)) rat_alarm_trim_inst (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .reg_req_in(reg_req),
        .reg_rdata_out(reg_rdata_out), .sec_tick_in(sec_tick_in), .time_in(time_in),
        .on_battery_in(on_battery_in), .fout_wave_in(fout_wave_in), .event_b_out(event_b_out),
        .frequency_out_select_out(frequency_out_select_out), .trim_out(trim_out));
    rat_host_model rat_host_model_inst (.clk_in(clk_in), .reg_rdata_in(reg_rdata_out), .reg_req_out(reg_req));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic tick(input logic [47:0] tv);
        time_in = tv;
        sec_tick_in = 1'b1;
        @(negedge clk_in);
        sec_tick_in = 1'b0;
        repeat (2) @(negedge clk_in);
    endtask
    task automatic pulse_len();
        lo = 0;
        while (event_b_out === 1'b0 && lo < 200) begin
            @(negedge clk_in);
            lo++;
        end
        chk(8'(lo >= PC - 2 && lo <= PC + 2), 8'h01, "pulse length");
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_in);
        n_fail++;
        conclude();
    end
    initial begin
        repeat (4) @(negedge clk_in);
        rst_b_in = 1'b1;
        @(negedge clk_in);
        foreach (regs[i]) begin
            rat_host_model_inst.rd(regs[i], 1'b0, rv);
            chk(rv, 8'h00, "reset value");
        end
        chk(8'(trim_out.cx_half_pf), 8'h32, "reset cx");
        chk({7'h0, event_b_out}, 8'h01, "reset pin");
        $display("test reset done");
        foreach (ana[i]) begin
            rat_host_model_inst.wr(rat_pkg::ADDR_ANALOG_TRIM, ana[i]);
            on_battery_in = 1'b1;
            repeat (8) @(negedge clk_in);
            e = (ana[i][5] ? 0 : 32) + int'(ana[i][4:0]) + 18;
            chk(8'(trim_out.cx_half_pf), 8'(e), "cx");
            chk(8'(trim_out.load_qpf), 8'(e + bo[ana[i][7:6]]), "load on battery");
            on_battery_in = 1'b0;
            repeat (8) @(negedge clk_in);
            chk(8'(trim_out.load_qpf), 8'(e), "load on mains");
            rat_host_model_inst.rd(rat_pkg::ADDR_ANALOG_TRIM, 1'b0, rv);
            chk(rv, ana[i], "analog readback");
        end
        for (int c = 0; c < 8; c++) begin
            rat_host_model_inst.wr(rat_pkg::ADDR_DIGITAL_TRIM, 8'(c));
            chk(8'(trim_out.rate_ppm), 8'(rt[c]), "rate");
        end
        ce_in = 1'b0;
        rat_host_model_inst.wr(rat_pkg::ADDR_DIGITAL_TRIM, 8'h03);
        ce_in = 1'b1;
        rat_host_model_inst.rd(rat_pkg::ADDR_DIGITAL_TRIM, 1'b0, rv);
        chk(rv, 8'h07, "write with enable low");
        $display("test trim done");
        for (int i = 0; i < 6; i++) begin
            rat_host_model_inst.wr(rat_pkg::ADDR_ALARM_FIRST + 8'(i), al1[i]);
        end
        rat_host_model_inst.wr(rat_pkg::ADDR_EVENT_CTRL, 8'h40);
        rat_host_model_inst.wr(rat_pkg::ADDR_STATUS, 8'h04);
        tick(48'h03_01_01_11_29_59);
        chk({7'h0, event_b_out}, 8'h01, "early pin");
        rat_host_model_inst.rd(rat_pkg::ADDR_STATUS, 1'b0, rv);
        chk(rv, 8'h00, "flag after write one");
        tick(T_MATCH);
        repeat (10) @(negedge clk_in);
        chk({7'h0, event_b_out}, 8'h00, "single pin");
        rat_host_model_inst.rd(rat_pkg::ADDR_STATUS, 1'b0, rv);
        chk(rv, 8'h04, "single flag");
        rat_host_model_inst.wr(rat_pkg::ADDR_STATUS, 8'h00);
        repeat (5) @(negedge clk_in);
        chk({7'h0, event_b_out}, 8'h01, "pin after clear");
        rat_host_model_inst.wr(rat_pkg::ADDR_STATUS, 8'h80);
        tick(T_MATCH);
        rat_host_model_inst.rd(rat_pkg::ADDR_STATUS, 1'b1, rv);
        chk(rv, 8'h84, "flag before auto clear");
        chk({7'h0, event_b_out}, 8'h01, "pin after auto clear");
        rat_host_model_inst.rd(rat_pkg::ADDR_STATUS, 1'b0, rv);
        chk(rv, 8'h80, "flag after auto clear");
        $display("test single alarm done");
        rat_host_model_inst.wr(rat_pkg::ADDR_EVENT_CTRL, 8'h41);
        chk({4'h0, frequency_out_select_out}, 8'h01, "frequency code");
        fout_wave_in = 1'b1;
        repeat (8) @(negedge clk_in);
        chk({7'h0, event_b_out}, 8'h01, "wave high");
        fout_wave_in = 1'b0;
        tick(T_MATCH);
        repeat (6) @(negedge clk_in);
        chk({7'h0, event_b_out}, 8'h00, "wave low");
        rat_host_model_inst.rd(rat_pkg::ADDR_STATUS, 1'b0, rv);
        chk(rv, 8'h80, "no flag in frequency mode");
        $display("test frequency mode done");
        for (int i = 0; i < 6; i++) begin
            rat_host_model_inst.wr(rat_pkg::ADDR_ALARM_FIRST + 8'(i), 8'h05);
        end
        rat_host_model_inst.wr(rat_pkg::ADDR_EVENT_CTRL, 8'hc0);
        tick({6{8'h05}});
        chk({7'h0, event_b_out}, 8'h01, "no byte enabled");
        for (int i = 0; i < 6; i++) begin
            rat_host_model_inst.wr(rat_pkg::ADDR_ALARM_FIRST + 8'(i), 8'h85);
            t = {6{8'h05}};
            t[i * 8 +: 8] = 8'h06;
            tick(t);
            chk({7'h0, event_b_out}, 8'h01, "field mismatch");
            tick({6{8'h05}});
            chk({7'h0, event_b_out}, 8'h00, "periodic pulse");
            pulse_len();
            rat_host_model_inst.wr(rat_pkg::ADDR_ALARM_FIRST + 8'(i), 8'h05);
        end
        rat_host_model_inst.rd(rat_pkg::ADDR_STATUS, 1'b0, rv);
        chk(rv, 8'h84, "periodic flag");
        $display("test periodic alarm done");
        conclude();
    end
endmodule
